// [hw/accel_hold_init.sv]
// Output coding, capture/hold and init sequencing for a two-axis sensor.
// Assumes samples arrive on pclk with a one-cycle strobe, pins are async.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module accel_hold_init
   import accel_hold_pkg::*;
#(
   parameter int PH1_CYCLES     = PH1_CYC,
   parameter int PH2_CYCLES     = PH2_CYC,
   parameter int PH2_HPF_CYCLES = PH2_HPF_CYC
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                supply_ok,
   input  wire logic                rail_a_ok,
   input  wire logic                rail_b_ok,
   input  wire logic                capture_hold_input,
   input  wire logic                sample_stb,
   input  wire logic [FILT_W-1:0]   filt_x,
   input  wire logic [FILT_W-1:0]   filt_y,
   input  wire logic [7:0]          fuse_rdata,
   output      logic [3:0]          fuse_addr,
   output      logic                fuse_power,
   output      logic [7:0]          trim_mirror,
   output      logic                serial_enable,
   output      logic                hpf_init,
   output      logic                selftest_active,
   output      logic                hold_sync,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output      logic [31:0]         prdata,
   output      logic                pready,
   output      logic                pslverr
);
   logic [2:0]  mon_s1_ff, mon_s2_ff;
   logic        hold_s1_ff, hold_s2_ff;
   logic        rst_int_n;
   init_t       phase_ff, nxt_phase;
   logic [27:0] cnt_ff;
   logic [4:0]  fuse_idx_ff;
   logic [7:0]  cfg_ff;
   logic        res_ff, st_ff;
   logic [10:0] proc_x_ff, proc_y_ff, buf_x_ff, buf_y_ff;
   logic [10:0] code_x, code_y;
   logic        ph1, ph2, done, wr_acc, rd_acc, ce_wr;
   logic [27:0] ph2_len;

   // Rail monitors cross domains; two flops before anyone looks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mon_s1_ff  <= 3'h0;
         mon_s2_ff  <= 3'h0;
         hold_s1_ff <= 1'b0;
         hold_s2_ff <= 1'b0;
      end else begin
         mon_s1_ff  <= {supply_ok, rail_a_ok, rail_b_ok};
         mon_s2_ff  <= mon_s1_ff;
         hold_s1_ff <= capture_hold_input;
         hold_s2_ff <= hold_s1_ff;
      end
   end
   assign rst_int_n = &mon_s2_ff;
   assign hold_sync = hold_s2_ff;

   assign ph1     = (phase_ff == PH_ONE);
   assign ph2     = (phase_ff == PH_TWO);
   assign done    = (phase_ff == PH_DONE);
   assign ph2_len = cfg_ff[CFG_HPF_BIT] ? 28'(PH2_HPF_CYCLES - 1)
                                        : 28'(PH2_CYCLES - 1);

   always_comb begin
      nxt_phase = phase_ff;
      case (phase_ff)
         PH_ONE:  if (cnt_ff == 28'(PH1_CYCLES - 1)) nxt_phase = PH_TWO;
         PH_TWO:  if (cnt_ff == ph2_len) nxt_phase = PH_DONE;
         PH_DONE: nxt_phase = PH_DONE;
         default: nxt_phase = PH_ONE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_ff <= PH_ONE;
         cnt_ff   <= 28'h000_0000;
      end else if (!rst_int_n) begin
         phase_ff <= PH_ONE;
         cnt_ff   <= 28'h000_0000;
      end else begin
         phase_ff <= nxt_phase;
         cnt_ff   <= (nxt_phase != phase_ff) ? 28'h000_0000 : cnt_ff + 28'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fuse_idx_ff <= 5'h00;
         trim_mirror <= 8'h00;
      end else if (!rst_int_n) begin
         fuse_idx_ff <= 5'h00;
         trim_mirror <= 8'h00;
      end else if (ph1 && !fuse_idx_ff[4]) begin
         fuse_idx_ff <= fuse_idx_ff + 5'h01;
         trim_mirror <= trim_mirror ^ fuse_rdata;
      end
   end
   assign fuse_addr  = fuse_idx_ff[3:0];
   assign fuse_power = ph1 && !fuse_idx_ff[4];
   assign hpf_init   = ph2 && cfg_ff[CFG_HPF_BIT];

   function automatic logic [10:0] encode(input logic [FILT_W-1:0] v);
      logic signed [FILT_W-1:0] s;
      logic [FILT_W-1:0]        biased;
      s      = signed'(v);
      biased = v + 16'(CODE_ZERO);
      if (s >= signed'(FILT_LIM))          encode = CODE_OVFL;
      else if (s <= -signed'(FILT_LIM))    encode = CODE_UNFL;
      else if (s >= signed'(FULL_SCALE))   encode = CODE_OVRNG;
      else if (s <= -signed'(FULL_SCALE))  encode = CODE_UNRNG;
      else if (biased[10:0] > CODE_MAX)    encode = CODE_MAX;
      else if (biased[10:0] < CODE_MIN)    encode = CODE_MIN;
      else                                 encode = biased[10:0];
   endfunction
   assign code_x = encode(filt_x);
   assign code_y = encode(filt_y);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         proc_x_ff <= CODE_ZERO;
         proc_y_ff <= CODE_ZERO;
      end else if (sample_stb) begin
         proc_x_ff <= code_x;
         proc_y_ff <= code_y;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_x_ff <= CODE_ZERO;
         buf_y_ff <= CODE_ZERO;
      end else if (!hold_s2_ff) begin
         buf_x_ff <= proc_x_ff;
         buf_y_ff <= proc_y_ff;
      end
   end

   assign pready  = !ph1;
   assign pslverr = 1'b0;
   assign serial_enable = !ph1;
   assign wr_acc  = psel && penable && pready && pwrite;
   assign rd_acc  = psel && penable && pready && !pwrite;
   assign ce_wr   = wr_acc && (paddr == OFF_CONTROL) && pwdata[CTL_CE_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff <= CFG_RST;
         st_ff  <= 1'b0;
         res_ff <= 1'b1;
      end else if (!rst_int_n) begin
         cfg_ff <= CFG_RST;
         st_ff  <= 1'b0;
         res_ff <= 1'b1;
      end else begin
         if (wr_acc && paddr == OFF_CONFIG) cfg_ff <= pwdata[7:0];
         if (wr_acc && paddr == OFF_CONTROL) st_ff <= pwdata[CTL_ST_BIT];
         if (ce_wr && done) res_ff <= 1'b0;
      end
   end
   assign selftest_active = st_ff;

   logic [1:0]  exc_class;
   logic        behav;
   assign behav = hold_s2_ff || st_ff;
   assign exc_class = (res_ff || !done) ? EXC_CRIT :
                      (hold_s2_ff && st_ff) ? EXC_TRANS :
                      behav ? EXC_BEHAV : EXC_NONE;

   // signed word option
   // Mode bit is an argument so the assigns follow a config write
   function automatic logic [10:0] shape(input logic        sd,
                                         input logic [10:0] c);
      shape = sd ? (c ^ 11'h400) : c;
   endfunction
   logic        sd_bit;
   logic [10:0] dx, dy;
   assign sd_bit = cfg_ff[CFG_SD_BIT];
   assign dx = (!done || res_ff) ? CODE_CRIT : shape(sd_bit, buf_x_ff);
   assign dy = (!done || res_ff) ? CODE_CRIT : shape(sd_bit, buf_y_ff);
   logic [31:0] status_w, rd_mux;
   assign status_w = {27'h000_0000, hpf_init, fuse_power, ph1, res_ff,
                      !done};
   assign rd_mux = (paddr == OFF_CONFIG)  ? {24'h00_0000, cfg_ff} :
                   (paddr == OFF_STATUS)  ? status_w :
                   (paddr == OFF_CONTROL) ? {30'h0000_0000, st_ff, 1'b0} :
                   (paddr == OFF_DATA_X)  ? {21'h00_0000, dx} :
                   (paddr == OFF_DATA_Y)  ? {21'h00_0000, dy} :
                   (paddr == OFF_EXC)     ? {30'h0000_0000, exc_class} :
                   32'h0000_0000;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite) prdata <= rd_mux;
   end

   property p_init_bit;
      @(posedge pclk) disable iff (!presetn)
         !rst_int_n |=> ph1 && status_w[ST_INIT_BIT] && res_ff;
   endproperty
   a_init_bit: assert property (p_init_bit) else $error("init bit low");

   property p_ph1_silent;
      @(posedge pclk) disable iff (!presetn) ph1 |-> !pready;
   endproperty
   a_ph1_silent: assert property (p_ph1_silent) else $error("ph1 ready");

   property p_hold_freeze;
      @(posedge pclk) disable iff (!presetn)
         hold_s2_ff && $past(hold_s2_ff) |=> $stable(buf_x_ff);
   endproperty
   a_hold_freeze: assert property (p_hold_freeze) else $error("buf moved");

   property p_proc_runs;
      @(posedge pclk) disable iff (!presetn)
         sample_stb |=> proc_x_ff == $past(code_x);
   endproperty
   a_proc_runs: assert property (p_proc_runs) else $error("proc stalled");

   property p_ovfl;
      @(posedge pclk) disable iff (!presetn)
         signed'(filt_x) >= signed'(FILT_LIM) |-> code_x == CODE_OVFL;
   endproperty
   a_ovfl: assert property (p_ovfl) else $error("no overflow code");

   property p_unfl;
      @(posedge pclk) disable iff (!presetn)
         signed'(filt_x) <= -signed'(FILT_LIM) |-> code_x == CODE_UNFL;
   endproperty
   a_unfl: assert property (p_unfl) else $error("no underflow code");

   property p_ovrng;
      @(posedge pclk) disable iff (!presetn)
         signed'(filt_x) >= signed'(FULL_SCALE) &&
         signed'(filt_x) < signed'(FILT_LIM) |-> code_x == CODE_OVRNG;
   endproperty
   a_ovrng: assert property (p_ovrng) else $error("no overrange code");

   property p_ce_clear;
      @(posedge pclk) disable iff (!presetn)
         ce_wr && done && rst_int_n |=> !res_ff;
   endproperty
   a_ce_clear: assert property (p_ce_clear) else $error("res not cleared");

   property p_fuse_off;
      @(posedge pclk) disable iff (!presetn) !ph1 |-> !fuse_power;
   endproperty
   a_fuse_off: assert property (p_fuse_off) else $error("fuse powered");

   property p_res_held;
      @(posedge pclk) disable iff (!presetn)
         !done |=> res_ff;
   endproperty
   a_res_held: assert property (p_res_held) else $error("res dropped");

   // reset code on data before init ends
   property p_data_gate;
      @(posedge pclk) disable iff (!presetn)
         rd_acc && paddr == OFF_DATA_X && $past(!done)
         |-> prdata[10:0] == CODE_CRIT;
   endproperty
   a_data_gate: assert property (p_data_gate) else $error("data early");

   // signed mode flips only the top bit
   property p_signed;
      @(posedge pclk) disable iff (!presetn)
         done && !res_ff && sd_bit
         |-> dx[10] != buf_x_ff[10] && dx[9:0] == buf_x_ff[9:0];
   endproperty
   a_signed: assert property (p_signed) else $error("signed word");

   // after clearing, reads show the buffer
   property p_data_live;
      @(posedge pclk) disable iff (!presetn)
         done && !res_ff && !sd_bit |-> dx == buf_x_ff;
   endproperty
   a_data_live: assert property (p_data_live) else $error("data stuck");

   property p_no_rsvd;
      @(posedge pclk) disable iff (!presetn)
         sample_stb |-> code_x != CODE_CRIT && code_x != CODE_AXIS &&
                        code_x > CODE_SCLK_FAULT;
   endproperty
   a_no_rsvd: assert property (p_no_rsvd) else $error("reserved code");

   // code side follows input sign, no wrap
   property p_no_wrap;
      @(posedge pclk) disable iff (!presetn)
         sample_stb |-> (filt_x[FILT_W-1] ? code_x < CODE_ZERO
                                          : code_x >= CODE_ZERO);
   endproperty
   a_no_wrap: assert property (p_no_wrap) else $error("code wrapped");

   property p_unrng;
      @(posedge pclk) disable iff (!presetn)
         signed'(filt_x) <= -signed'(FULL_SCALE) &&
         signed'(filt_x) > -signed'(FILT_LIM) |-> code_x == CODE_UNRNG;
   endproperty
   a_unrng: assert property (p_unrng) else $error("no underrange");

   // zero input gives zero code next
   property p_recover;
      @(posedge pclk) disable iff (!presetn)
         sample_stb && filt_x == 16'h0000 |=> proc_x_ff == CODE_ZERO;
   endproperty
   a_recover: assert property (p_recover) else $error("no recovery");

   // hold keeps result latest at its edge
   property p_hold_last;
      @(posedge pclk) disable iff (!presetn)
         $rose(hold_s2_ff) |-> buf_x_ff == $past(proc_x_ff);
   endproperty
   a_hold_last: assert property (p_hold_last) else $error("hold stale");

   property p_proc_y;
      @(posedge pclk) disable iff (!presetn)
         sample_stb |=> proc_y_ff == $past(code_y);
   endproperty
   a_proc_y: assert property (p_proc_y) else $error("proc y stalled");

   property p_mon_rst;
      @(posedge pclk) disable iff (!presetn)
         !rst_int_n |=> ph1 && cnt_ff == 28'h000_0000 && fuse_idx_ff == 5'h00;
   endproperty
   a_mon_rst: assert property (p_mon_rst) else $error("init ran");

   // power drops only after full copy
   property p_fuse_done;
      @(posedge pclk) disable iff (!presetn)
         $fell(fuse_power) |-> fuse_idx_ff[4];
   endproperty
   a_fuse_done: assert property (p_fuse_done) else $error("copy cut");

   property p_exc_both;
      @(posedge pclk) disable iff (!presetn)
         done && !res_ff && hold_s2_ff && st_ff |-> exc_class == EXC_TRANS;
   endproperty
   a_exc_both: assert property (p_exc_both) else $error("exc both");

   property p_exc_one;
      @(posedge pclk) disable iff (!presetn)
         done && !res_ff && (hold_s2_ff != st_ff)
         |-> exc_class == EXC_BEHAV;
   endproperty
   a_exc_one: assert property (p_exc_one) else $error("exc one");

   // Main scenarios
   c_done:  cover property (@(posedge pclk) disable iff (!presetn) $rose(done));
   c_hold:  cover property (@(posedge pclk) disable iff (!presetn) $rose(hold_s2_ff));
   c_clear: cover property (@(posedge pclk) disable iff (!presetn) $fell(res_ff));
   c_ovfl:  cover property (@(posedge pclk) disable iff (!presetn)
                            sample_stb && code_x == CODE_OVFL);
   c_both:  cover property (@(posedge pclk) disable iff (!presetn)
                            exc_class == EXC_TRANS);
endmodule

// [hw/accel_hold_pkg.sv]
// Constants for the acceleration output hold and init block.
// Assumes pclk at 250 MHz and an APB master on the register side.
// Behaviour
// - Positive signal past full scale but computable reports over-range code.
// - Filter output at or above filter limit clips and reports overflow code.
// - Negative side mirrors: under-range code and underflow code.
// - After overflow, normal output resumes within a few samples.
// - While capture_hold_input is high, output buffers are not updated.
// - Processing keeps sampling whatever capture_hold_input level.
// - Reads during hold return results latest when hold went high.
// - Reset held until supply and both rail monitors are good.
// - Every reset runs a two-phase initialization.
// - Phase one copies fuses to mirrors, then powers fuses off; the code XORs all 16 fuse bytes into the one trim_mirror.
// - Serial accesses are ignored with no response in phase one.
// - Phase two: registers work, acceleration reads get non-data answer.
// - With highpass_select_bit set, phase two also initializes highpass.
// - Phase one lasts about 800 us.
// - Phase two lasts 3.0 ms, or 200 ms with highpass selected.
// - init_in_progress_bit set by reset until phase two ends.
// - Writing one to clear-exception after phase two ends drops reset_occurred_bit.
// - After clearing, registers and acceleration reads work in any order.
// - Filter saturates before datapath width, so datapath never wraps.
// - Hold or self-test is behavioural exception; both gives combined one.
// - signed_data_bit selects signed or unsigned acceleration words.
package accel_hold_pkg;
   localparam int          CLK_MHZ         = 250;
   localparam int          PH1_US          = 800;
   localparam int          PH2_US          = 3000;
   localparam int          PH2_HPF_US      = 200000;
   localparam int          PH1_CYC         = PH1_US * CLK_MHZ;
   localparam int          PH2_CYC         = PH2_US * CLK_MHZ;
   localparam int          PH2_HPF_CYC     = PH2_HPF_US * CLK_MHZ;
   localparam logic [10:0] CODE_CRIT       = 11'h7ff;
   localparam logic [10:0] CODE_AXIS       = 11'h7fe;
   localparam logic [10:0] CODE_OVFL       = 11'h7fd;
   localparam logic [10:0] CODE_OVRNG      = 11'h7fc;
   localparam logic [10:0] CODE_MAX        = 11'h7fb;
   localparam logic [10:0] CODE_ZERO       = 11'h400;
   localparam logic [10:0] CODE_MIN        = 11'h005;
   localparam logic [10:0] CODE_UNRNG      = 11'h004;
   localparam logic [10:0] CODE_UNFL       = 11'h003;
   localparam logic [10:0] CODE_SCLK_FAULT = 11'h002;
   localparam logic [10:0] CODE_PAR_FAULT  = 11'h001;
   localparam logic [10:0] CODE_RSVD       = 11'h000;
   // Signed filter output span; beyond FILT_LIM the filter saturates
   localparam int          FILT_W          = 16;
   localparam logic [15:0] FILT_LIM        = 16'h2000;
   localparam logic [15:0] FULL_SCALE      = 16'h0400;
   localparam logic [11:0] OFF_CONFIG      = 12'h000;
   localparam logic [11:0] OFF_STATUS      = 12'h004;
   localparam logic [11:0] OFF_CONTROL     = 12'h008;
   localparam logic [11:0] OFF_DATA_X      = 12'h00c;
   localparam logic [11:0] OFF_DATA_Y      = 12'h010;
   localparam logic [11:0] OFF_EXC         = 12'h014;
   localparam int          CFG_HPF_BIT     = 0;
   localparam int          CFG_SD_BIT      = 1;
   localparam int          ST_INIT_BIT     = 0;
   localparam int          ST_RES_BIT      = 1;
   localparam int          ST_PH1_BIT      = 2;
   localparam int          ST_FUSEPWR_BIT  = 3;
   localparam int          ST_HPFI_BIT     = 4;
   localparam int          CTL_CE_BIT      = 0;
   localparam int          CTL_ST_BIT      = 1;
   localparam logic [1:0]  EXC_NONE        = 2'h0;
   localparam logic [1:0]  EXC_BEHAV       = 2'h1;
   localparam logic [1:0]  EXC_CRIT        = 2'h2;
   localparam logic [1:0]  EXC_TRANS       = 2'h3;
   localparam logic [7:0]  CFG_RST         = 8'h00;
   typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_DONE} init_t;
endpackage

// [bench/fuse_array_model.sv]
// Fuse array stand-in seen by the init block during phase one.
// Assumes fuse_addr and fuse_power come from the block on pclk.
`timescale 1ns/1ps
module fuse_array_model (
   input  wire logic       pclk,
   input  wire logic       fuse_power,
   input  wire logic [3:0] fuse_addr,
   output      logic [7:0] fuse_rdata
);
   logic [7:0] junk_ff = 8'h55;
   // Unpowered array gives a toggling pattern, never stale data
   always_ff @(posedge pclk) begin
      junk_ff <= ~junk_ff;
   end
   assign fuse_rdata = fuse_power ? (8'h3c + 8'(fuse_addr) * 8'h07)
                                  : junk_ff;
endmodule

// [bench/accel_output_hold_and_init_test.sv]
// Self-checking bench for accel_hold_init over APB.
// Assumes short init counts; fuse model sits on the fuse port.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; \
   if ((got) !== (ex)) begin n_errors++; \
   $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module accel_output_hold_and_init_test;
   import accel_hold_pkg::*;
   localparam int P1 = 20;
   localparam int P2 = 30;
   localparam int P2H = 50;
   logic        pclk = 0, presetn = 0;
   logic        supply_ok = 1, rail_a_ok = 1, rail_b_ok = 1;
   logic        capture_hold_input = 0, sample_stb = 0;
   logic [15:0] filt_x = 0, filt_y = 0;
   logic [7:0]  fuse_rdata, trim_mirror;
   logic [3:0]  fuse_addr;
   logic        fuse_power, serial_enable, hpf_init;
   logic        selftest_active, hold_sync, pready, pslverr;
   logic        psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rv;
   int          n_errors = 0, checks_done = 0, wait_n;
   accel_hold_init #(.PH1_CYCLES(P1), .PH2_CYCLES(P2),
      .PH2_HPF_CYCLES(P2H)) dut_u (.pclk(pclk), .presetn(presetn),
      .supply_ok(supply_ok), .rail_a_ok(rail_a_ok),
      .rail_b_ok(rail_b_ok), .capture_hold_input(capture_hold_input),
      .sample_stb(sample_stb), .filt_x(filt_x), .filt_y(filt_y),
      .fuse_rdata(fuse_rdata), .fuse_addr(fuse_addr),
      .fuse_power(fuse_power), .trim_mirror(trim_mirror),
      .serial_enable(serial_enable), .hpf_init(hpf_init),
      .selftest_active(selftest_active), .hold_sync(hold_sync),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   fuse_array_model fm_u (.pclk(pclk), .fuse_power(fuse_power),
      .fuse_addr(fuse_addr), .fuse_rdata(fuse_rdata));
   initial begin
      forever #2 pclk = ~pclk;
   end
   task automatic complete_run;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      wait_n = 0;
      // pready moves only on rising edges; mid-cycle shows the next edge
      @(negedge pclk);
      while (pready !== 1'b1 && wait_n < 400) begin
         @(negedge pclk);
         wait_n++;
      end
      @(posedge pclk);
      r = prdata;
      if (wait_n >= 400) begin
         n_errors++;
         $display("[ERR] pready exp 1 got %b", pready);
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rv);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0000_0000, rv);
   endtask
   task automatic send(input logic [15:0] x, input logic [15:0] y);
      repeat (3) begin
         @(posedge pclk);
         sample_stb <= 1'b1;
         filt_x     <= x;
         filt_y     <= y;
         @(posedge pclk);
         sample_stb <= 1'b0;
      end
   endtask
   task automatic t_phase_one;
      logic [7:0] tx;
      tx = 8'h00;
      for (int i = 0; i < 16; i++) tx ^= 8'h3c + 8'(i) * 8'h07;
      repeat (5) @(posedge pclk);
      `CHK("fuse_power", 1'b1, fuse_power)
      `CHK("serial_enable", 1'b0, serial_enable)
      rd(OFF_STATUS);
      `CHK("ph1_stall", 1'b1, wait_n >= P1 - 8)
      `CHK("ph1_len", 1'b1, (wait_n + 7 >= P1) && (wait_n <= P1 + 8))
      `CHK("fuse_off", 1'b0, fuse_power)
      `CHK("trim", tx, trim_mirror)
      `CHK("fuse_addr", 4'h0, fuse_addr)
   endtask
   task automatic t_phase_two;
      rd(OFF_DATA_X);
      `CHK("data_ph2", 32'(CODE_CRIT), rv)
      rd(OFF_STATUS);
      `CHK("init_bit", 2'b11, rv[1:0])
      wr(OFF_CONTROL, 32'h0000_0001);
      repeat (P2 + 10) @(posedge pclk);
      rd(OFF_STATUS);
      `CHK("init_done", 2'b10, rv[1:0])
      rd(OFF_EXC);
      `CHK("exc_crit", 32'(EXC_CRIT), rv)
      rd(OFF_DATA_Y);
      `CHK("data_unclr", 32'(CODE_CRIT), rv)
      wr(OFF_CONTROL, 32'h0000_0001);
      rd(OFF_STATUS);
      `CHK("res_clr", 1'b0, rv[ST_RES_BIT])
      rd(OFF_EXC);
      `CHK("exc_none", 32'(EXC_NONE), rv)
   endtask
   task automatic t_codes;
      logic [15:0] xin [8];
      logic [10:0] xcd [8];
      xin = '{16'h0000, 16'h1000, 16'h2000, 16'h0000,
              16'h7fff, 16'hf000, 16'he000, 16'h8000};
      xcd = '{CODE_ZERO, CODE_OVRNG, CODE_OVFL, CODE_ZERO,
              CODE_OVFL, CODE_UNRNG, CODE_UNFL, CODE_UNFL};
      for (int i = 0; i < 8; i++) begin
         send(xin[i], 16'h0000);
         rd(OFF_DATA_X);
         `CHK("code_x", 32'(xcd[i]), rv)
         rd(OFF_DATA_Y);
         `CHK("code_y", 32'(CODE_ZERO), rv)
      end
      send(16'h0000, 16'h0000);
      rd(OFF_DATA_X);
      `CHK("recover", 32'(CODE_ZERO), rv)
   endtask
   task automatic t_hold;
      send(16'h1000, 16'hf000);
      @(posedge pclk);
      capture_hold_input <= 1;
      repeat (5) @(posedge pclk);
      `CHK("hold_sync", 1'b1, hold_sync)
      send(16'h0000, 16'h0000);
      rd(OFF_DATA_X);
      `CHK("held_x", 32'(CODE_OVRNG), rv)
      rd(OFF_DATA_Y);
      `CHK("held_y", 32'(CODE_UNRNG), rv)
      rd(OFF_EXC);
      `CHK("exc_hold", 32'(EXC_BEHAV), rv)
      wr(OFF_CONTROL, 32'h0000_0002);
      @(negedge pclk);
      `CHK("selftest", 1'b1, selftest_active)
      rd(OFF_EXC);
      `CHK("exc_both", 32'(EXC_TRANS), rv)
      capture_hold_input <= 0;
      repeat (6) @(posedge pclk);
      rd(OFF_DATA_X);
      `CHK("unheld_x", 32'(CODE_ZERO), rv)
      rd(OFF_EXC);
      `CHK("exc_st", 32'(EXC_BEHAV), rv)
      wr(OFF_CONTROL, 32'h0000_0000);
   endtask
   task automatic t_signed;
      wr(OFF_CONFIG, 32'h0000_0002);
      send(16'h0000, 16'h0000);
      rd(OFF_DATA_X);
      `CHK("signed0", 32'(CODE_ZERO ^ 11'h400), rv)
      wr(OFF_CONFIG, 32'h0000_0000);
      rd(OFF_DATA_X);
      `CHK("unsigned0", 32'(CODE_ZERO), rv)
      rd(12'h0f0);
      `CHK("unmapped", 32'h0000_0000, rv)
      `CHK("pslverr", 1'b0, pslverr)
   endtask
   task automatic t_monitor;
      rail_b_ok <= 0;
      repeat (8) @(posedge pclk);
      `CHK("mon_se", 1'b0, serial_enable)
      repeat (P1 + 5) @(posedge pclk);
      `CHK("mon_hold", 1'b0, serial_enable)
      rail_b_ok <= 1;
      wr(OFF_CONFIG, 32'h0000_0001);
      @(negedge pclk);
      `CHK("hpf_init", 1'b1, hpf_init)
      rd(OFF_STATUS);
      `CHK("res_again", 3'b011, rv[2:0])
      repeat (P2 + 5) @(posedge pclk);
      rd(OFF_STATUS);
      `CHK("hpf_long", 1'b1, rv[ST_INIT_BIT])
      repeat (P2H - P2 + 5) @(posedge pclk);
      rd(OFF_STATUS);
      `CHK("hpf_done", 1'b0, rv[ST_INIT_BIT])
      `CHK("hpf_off", 1'b0, hpf_init)
   endtask
   initial begin
      // Generous bound: whole sequence needs well under 4000 cycles
      #80000;
      n_errors++;
      complete_run();
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      t_phase_one();
      t_phase_two();
      t_codes();
      t_hold();
      t_signed();
      t_monitor();
      complete_run();
   end
endmodule
